// ---- hdl/cmd_decode_pkg.sv ----
// Shared types and constants for the command and clock-enable decoder.
// Assumes a single core clock; command/address pins are synchronous to it.
package cmd_decode_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int CA_W = 10;
    localparam int BANK_W = 3;
    localparam int BANKS = 8;
    localparam int ROW_W = 15;
    localparam int COL_W = 12;
    localparam int MRA_W = 8;
    localparam int MRO_W = 8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BANK_LSB = 7;
    localparam int AP_POS = 0;
    localparam int AB_POS = 4;
    localparam int MRA_LO_LSB = 4;
    localparam int OP_LSB = 2;

    // ****************************************
    // Command codes
    // ****************************************
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_MRW,
        CMD_MRR,
        CMD_REF_BANK,
        CMD_REF_ALL,
        CMD_ACT,
        CMD_WRITE,
        CMD_READ,
        CMD_PRE,
        CMD_BST,
        CMD_SELF_REFRESH_STATE_ENTER,
        CMD_DPD_ENTER,
        CMD_PD_ENTER,
        CMD_PD_EXIT,
        CMD_HOLD,
        CMD_ILLEGAL
    } cmd_e;

    // ****************************************
    // Bus states
    // ****************************************
    typedef enum logic [3:0] {
        ST_POWER_ON,
        ST_RESETTING,
        ST_IDLE,
        ST_ACTIVE,
        ST_IDLE_PD,
        ST_ACTIVE_PD,
        ST_RESET_PD,
        ST_SELF_REFRESH,
        ST_DEEP_PD,
        ST_ERROR
    } bus_state_e;

    // Decoded command with its address fields
    typedef struct packed {
        cmd_e cmd;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic auto_precharge_bit;
        logic all_banks_bit;
        logic [MRA_W-1:0] mr_addr;
        logic [MRO_W-1:0] mr_operand;
    } cmd_s;

    localparam logic [3:0] RESET_NO_PRE = 4'h0;

endpackage

// ---- hdl/cmd_classify.sv ----
// Rising-edge command classifier: pure combinational decode of pin levels.
// Assumes inputs are sampled levels from the rising edge.
`timescale 1ns/1ps
module cmd_classify
    import cmd_decode_pkg::*;
(
    input wire logic i_cke_prev,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic [3:0] i_ca,
    output cmd_decode_pkg::cmd_e o_cmd
);
    import cmd_decode_pkg::*;

    // ****************************************
    // Decode
    // ****************************************
    always_comb begin
        o_cmd = CMD_ILLEGAL;
        if (!i_cke_prev && !i_cke) begin
            o_cmd = CMD_HOLD;
        end else if (!i_cke_prev && i_cke) begin
            o_cmd = i_cs_n ? CMD_PD_EXIT : CMD_ILLEGAL;
        end else if (i_cke_prev && !i_cke) begin
            if (i_cs_n) begin
                o_cmd = CMD_PD_ENTER;
            end else if (i_ca[2:0] == 3'h4) begin
                o_cmd = CMD_SELF_REFRESH_STATE_ENTER;
            end else if (i_ca[2:0] == 3'h3) begin
                o_cmd = CMD_DPD_ENTER;
            end
        end else if (i_cs_n) begin
            o_cmd = CMD_NOP;
        end else begin
            case (i_ca)
                4'h0: o_cmd = CMD_MRW;
                4'h8: o_cmd = CMD_MRR;
                4'h4: o_cmd = CMD_REF_BANK;
                4'hc: o_cmd = CMD_REF_ALL;
                4'h1: o_cmd = CMD_WRITE;
                4'h9: o_cmd = CMD_WRITE;
                4'h5: o_cmd = CMD_READ;
                4'hd: o_cmd = CMD_READ;
                4'hb: o_cmd = CMD_PRE;
                4'h3: o_cmd = CMD_BST;
                4'h7: o_cmd = CMD_NOP;
                4'hf: o_cmd = CMD_NOP;
                default: begin
                    if (i_ca[1:0] == 2'h2) begin
                        o_cmd = CMD_ACT;
                    end else begin
                        o_cmd = CMD_ILLEGAL;
                    end
                end
            endcase
        end
    end

endmodule

// ---- hdl/lpddr2_command_cke_decoder.sv ----
// Command and clock-enable decoder at the command/address port.
// Assumes CA half captured by the caller on the falling edge is presented
// on i_ca_fall one cycle after the rising-edge half; pins synchronous.
`timescale 1ns/1ps
module lpddr2_command_cke_decoder #(
    parameter int NUM_BANKS = 8
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_cke,
    input wire logic [cmd_decode_pkg::CA_W-1:0] i_ca_rise,
    input wire logic [cmd_decode_pkg::CA_W-1:0] i_ca_fall,
    input wire logic i_init_wait_done,
    input wire logic i_reset_cmd,
    input wire logic i_reset_done,
    output cmd_decode_pkg::cmd_s o_cmd,
    output logic o_cmd_valid,
    output cmd_decode_pkg::bus_state_e o_state,
    output logic [cmd_decode_pkg::BANKS-1:0] o_bank_open,
    output logic [cmd_decode_pkg::BANKS-1:0] o_ap_pending,
    output logic o_illegal
);
    import cmd_decode_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic cke_prev_r;
    logic cke_async_r;
    logic cke_meta_r;
    logic cke_sync_r;
    cmd_e cls;
    cmd_e pend_cmd_r;
    logic [CA_W-1:0] pend_rise_r;
    logic pend_r;
    bus_state_e state_r;
    bus_state_e state_nxt;
    cmd_s cmd_r;
    logic cmd_valid_r;
    logic [BANKS-1:0] open_r;
    logic [BANKS-1:0] ap_r;
    logic illegal_r;
    logic [BANK_W-1:0] pend_bank;
    logic low_power_hold;
    logic lp_low_seen_r;

    // Bit select mask for one bank
    function automatic logic [BANKS-1:0] bank_mask(input logic [BANK_W-1:0] b);
        bank_mask = '0;
        bank_mask[b] = 1'b1;
    endfunction

    cmd_classify u_classify (
        .i_cke_prev(cke_prev_r),
        .i_cke(i_cke),
        .i_cs_n(i_cs_n),
        .i_ca(i_ca_rise[3:0]),
        .o_cmd(cls)
    );

    assign pend_bank = pend_rise_r[BANK_LSB +: BANK_W];
    assign low_power_hold = (state_r == ST_SELF_REFRESH) || (state_r == ST_DEEP_PD);

    // ****************************************
    // Clock-enable sampling
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cke_prev_r <= 1'b0;
        end else begin
            cke_prev_r <= i_cke;
        end
    end

    // Exit wake-up: latch a rise of the enable even with the clock stopped
    always_ff @(posedge i_cke or negedge i_resetn) begin
        if (!i_resetn) begin
            cke_async_r <= 1'b0;
        end else begin
            cke_async_r <= 1'b1;
        end
    end

    // Synchroniser; first stage read only by second
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cke_meta_r <= 1'b0;
            cke_sync_r <= 1'b0;
        end else begin
            cke_meta_r <= cke_async_r & i_cke;
            cke_sync_r <= cke_meta_r;
        end
    end

    // Synchroniser lags entry; wait for it to show enable low before exit
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lp_low_seen_r <= 1'b0;
        end else if (!low_power_hold) begin
            lp_low_seen_r <= 1'b0;
        end else if (!cke_sync_r) begin
            lp_low_seen_r <= 1'b1;
        end
    end

    // ****************************************
    // Rising half capture
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pend_r <= 1'b0;
            pend_cmd_r <= CMD_NOP;
            pend_rise_r <= '0;
        end else begin
            pend_r <= 1'b1;
            pend_cmd_r <= cls;
            pend_rise_r <= i_ca_rise;
        end
    end

    // ****************************************
    // Field assembly from both halves
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_r <= '0;
            cmd_valid_r <= 1'b0;
        end else begin
            cmd_valid_r <= pend_r && (pend_cmd_r != CMD_HOLD) && (pend_cmd_r != CMD_NOP);
            cmd_r.cmd <= pend_cmd_r;
            cmd_r.bank <= pend_bank;
            cmd_r.row <= {i_ca_fall[9:8], pend_rise_r[6:2], i_ca_fall[7:0]};
            cmd_r.col <= {i_ca_fall[9:1], pend_rise_r[6:5], 1'b0};
            cmd_r.auto_precharge_bit <= i_ca_fall[AP_POS];
            cmd_r.all_banks_bit <= pend_rise_r[AB_POS];
            cmd_r.mr_addr <= {i_ca_fall[1:0], pend_rise_r[MRA_LO_LSB +: 6]};
            cmd_r.mr_operand <= i_ca_fall[OP_LSB +: MRO_W];
        end
    end

    // ****************************************
    // Bank bookkeeping
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            open_r <= '0;
            ap_r <= '0;
        end else if (cmd_valid_r) begin
            case (cmd_r.cmd)
                CMD_ACT: open_r <= open_r | bank_mask(cmd_r.bank);
                CMD_PRE: begin
                    if (cmd_r.all_banks_bit) begin
                        open_r <= '0;
                    end else begin
                        open_r <= open_r & ~bank_mask(cmd_r.bank);
                    end
                end
                CMD_READ, CMD_WRITE: begin
                    if (cmd_r.auto_precharge_bit) begin
                        ap_r <= ap_r | bank_mask(cmd_r.bank);
                    end
                end
                CMD_BST: begin
                    // Burst end closes any auto-precharge access
                    open_r <= open_r & ~ap_r;
                    ap_r <= '0;
                end
                default: begin
                    open_r <= open_r & ~ap_r;
                    ap_r <= '0;
                end
            endcase
        end else begin
            // Simplified: auto precharge completes on next idle cycle
            open_r <= open_r & ~ap_r;
            ap_r <= '0;
        end
    end

    // ****************************************
    // Bus state machine
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_POWER_ON: begin
                if (i_reset_cmd) begin
                    state_nxt = ST_RESETTING;
                end
            end
            ST_RESETTING: begin
                if (cls == CMD_PD_ENTER) begin
                    state_nxt = ST_RESET_PD;
                end else if (i_reset_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE, ST_ACTIVE: begin
                if (cls == CMD_PD_ENTER) begin
                    state_nxt = (open_r == '0) ? ST_IDLE_PD : ST_ACTIVE_PD;
                end else if (cls == CMD_SELF_REFRESH_STATE_ENTER && open_r == '0) begin
                    state_nxt = ST_SELF_REFRESH;
                end else if (cls == CMD_DPD_ENTER && open_r == '0) begin
                    state_nxt = ST_DEEP_PD;
                end else if (cls == CMD_REF_BANK && NUM_BANKS != BANKS) begin
                    state_nxt = ST_ERROR;
                end else if (cls == CMD_ILLEGAL || cls == CMD_SELF_REFRESH_STATE_ENTER
                        || cls == CMD_DPD_ENTER) begin
                    state_nxt = ST_ERROR;
                end else begin
                    state_nxt = (open_r == '0) ? ST_IDLE : ST_ACTIVE;
                end
            end
            ST_IDLE_PD: begin
                if (cls == CMD_PD_EXIT) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ACTIVE_PD: begin
                if (cls == CMD_PD_EXIT) begin
                    state_nxt = ST_ACTIVE;
                end
            end
            ST_RESET_PD: begin
                if (cls == CMD_PD_EXIT) begin
                    state_nxt = i_init_wait_done ? ST_IDLE : ST_RESETTING;
                end
            end
            ST_SELF_REFRESH: begin
                if (cke_sync_r && lp_low_seen_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DEEP_PD: begin
                if (cke_sync_r && lp_low_seen_r) begin
                    state_nxt = ST_POWER_ON;
                end
            end
            ST_ERROR: state_nxt = ST_ERROR;
            default: state_nxt = ST_ERROR;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= ST_POWER_ON;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Stays set until core reset: recovery needs full restart
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            illegal_r <= 1'b0;
        end else if (state_nxt == ST_ERROR) begin
            illegal_r <= 1'b1;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_cmd = cmd_r;
    assign o_cmd_valid = cmd_valid_r && !low_power_hold;
    assign o_state = state_r;
    assign o_bank_open = open_r;
    assign o_ap_pending = ap_r;
    assign o_illegal = illegal_r;

endmodule

// ---- bench/lpddr2_command_cke_decoder_props.sv ----
// Checker bound to the command and clock-enable decoder ports.
// Assumes the two-cycle command latency of the design.
`timescale 1ns/1ps
module decoder_checker
    import cmd_decode_pkg::*;
#(
    parameter int NUM_BANKS = 8
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_cke,
    input wire logic [cmd_decode_pkg::CA_W-1:0] i_ca_rise,
    input wire logic [cmd_decode_pkg::CA_W-1:0] i_ca_fall,
    input wire cmd_decode_pkg::cmd_s o_cmd,
    input wire logic o_cmd_valid,
    input wire cmd_decode_pkg::bus_state_e o_state,
    input wire logic [cmd_decode_pkg::BANKS-1:0] o_bank_open,
    input wire logic [cmd_decode_pkg::BANKS-1:0] o_ap_pending
);
    import cmd_decode_pkg::*;
    logic [CA_W-1:0] rise_d1_r, rise_d2_r, fall_d1_r;
    logic [BANK_W-1:0] bank_d1_r;
    logic acc_v;
    // ************
    // Pins delayed to line up with the answer
    // ************
    always_ff @(posedge i_core_clk) begin
        rise_d1_r <= i_ca_rise;
        rise_d2_r <= rise_d1_r;
        fall_d1_r <= i_ca_fall;
        bank_d1_r <= o_cmd.bank;
    end
    assign acc_v = o_cmd_valid && o_cmd.cmd inside {CMD_READ, CMD_WRITE};
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    act_decode_a: assert property (
        !i_cs_n && i_cke && $past(i_cke) && i_ca_rise[1:0] == 2'b10 && o_state == ST_IDLE
        |-> ##2 o_cmd_valid && o_cmd.cmd == CMD_ACT && o_cmd.bank == rise_d2_r[9:7])
        else $error("activate not decoded");
    col_field_a: assert property (
        acc_v |-> o_cmd.col == {fall_d1_r[9:1], rise_d2_r[6:5], 1'b0})
        else $error("column field wrong");
    mrw_field_a: assert property (
        o_cmd_valid && o_cmd.cmd == CMD_MRW |-> o_cmd.mr_operand == fall_d1_r[9:2]
        && o_cmd.mr_addr == {fall_d1_r[1:0], rise_d2_r[9:4]})
        else $error("mode write fields wrong");
    ap_bank_a: assert property (
        acc_v && o_cmd.auto_precharge_bit |=> o_ap_pending[bank_d1_r])
        else $error("auto precharge missing");
    idle_clear_a: assert property (
        $rose(o_state == ST_IDLE) |-> o_bank_open == '0)
        else $error("idle with open bank");
    pd_hold_a: assert property (
        o_state == ST_IDLE_PD && !i_cke |=> o_state == ST_IDLE_PD)
        else $error("power-down not held");
    self_refresh_state_entry_a: assert property (
        o_state == ST_IDLE && o_bank_open == '0 && !i_cs_n && !i_cke && $past(i_cke)
        && i_ca_rise[2:0] == 3'b100 |=> o_state == ST_SELF_REFRESH)
        else $error("self refresh not entered");
    dpd_exit_a: assert property (
        o_state == ST_DEEP_PD && i_cke |-> ##[1:4] o_state == ST_POWER_ON)
        else $error("deep power-down exit missing");
endmodule

bind lpddr2_command_cke_decoder decoder_checker #(.NUM_BANKS(NUM_BANKS)) u_checker (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_cke(i_cke),
    .i_ca_rise(i_ca_rise), .i_ca_fall(i_ca_fall), .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid),
    .o_state(o_state), .o_bank_open(o_bank_open), .o_ap_pending(o_ap_pending)
);

// ---- bench/ctrl_model.sv ----
// Controller model driving the command/address pins.
// Assumes the bench hands it one command per cycle as levels.
`timescale 1ns/1ps
module ctrl_model
    import cmd_decode_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_cs_n,
    input wire logic i_cke,
    input wire logic [cmd_decode_pkg::CA_W-1:0] i_rise,
    input wire logic [cmd_decode_pkg::CA_W-1:0] i_fall,
    output logic o_cs_n,
    output logic o_cke,
    output logic [cmd_decode_pkg::CA_W-1:0] o_ca_rise,
    output logic [cmd_decode_pkg::CA_W-1:0] o_ca_fall
);
    import cmd_decode_pkg::*;
    logic [CA_W-1:0] filler_r = 10'h2a5;
    // Deselected cycles carry defined but ever-changing levels
    always @(posedge i_core_clk) begin
        filler_r <= ~{filler_r[8:0], filler_r[9]};
        o_ca_fall <= i_cs_n ? ~filler_r : i_fall;
    end
    assign o_cs_n = i_cs_n;
    assign o_cke = i_cke;
    assign o_ca_rise = i_cs_n ? filler_r : i_rise;
endmodule

// ---- bench/lpddr2_command_cke_decoder_bench.sv ----
// Self-checking bench for the command and clock-enable decoder.
// Assumes ctrl_model on the pins and the bound decoder_checker.
`timescale 1ns/1ps
module lpddr2_command_cke_decoder_bench;
    import cmd_decode_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic cs_n = 1'b1;
    logic cke = 1'b0;
    logic init_done = 1'b0;
    logic rst_cmd = 1'b0;
    logic rst_done = 1'b0;
    logic [CA_W-1:0] rise = '0;
    logic [CA_W-1:0] fall = '0;
    logic p_cs_n, p_cke, valid, illegal;
    logic [CA_W-1:0] p_rise, p_fall;
    logic [BANKS-1:0] open_m, ap_m;
    cmd_s cmd;
    bus_state_e state;
    logic [2:0] b;
    logic [14:0] row;
    logic [11:0] col;
    logic [7:0] ma, op;
    int errors = 0;
    int checks = 0;
    int seed = 48;

    initial forever #10 i_core_clk = ~i_core_clk;

    ctrl_model u_ctrl (
        .i_core_clk(i_core_clk), .i_cs_n(cs_n), .i_cke(cke), .i_rise(rise), .i_fall(fall),
        .o_cs_n(p_cs_n), .o_cke(p_cke), .o_ca_rise(p_rise), .o_ca_fall(p_fall)
    );
    lpddr2_command_cke_decoder #(.NUM_BANKS(8)) uut (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cs_n(p_cs_n), .i_cke(p_cke),
        .i_ca_rise(p_rise), .i_ca_fall(p_fall), .i_init_wait_done(init_done),
        .i_reset_cmd(rst_cmd), .i_reset_done(rst_done), .o_cmd(cmd), .o_cmd_valid(valid),
        .o_state(state), .o_bank_open(open_m), .o_ap_pending(ap_m), .o_illegal(illegal)
    );

    // ************
    // Shared tasks
    // ************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Bounded poll; state latency differs between sync and async exits
    task automatic wait_st(input bus_state_e exp);
        int n = 0;
        while (state !== exp && n < 8) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        chk("state", exp, state);
    endtask

    task automatic issue(input logic [9:0] r, input logic [9:0] f, input cmd_e exp);
        @(posedge i_core_clk);
        cs_n <= 1'b0;
        cke <= 1'b1;
        rise <= r;
        fall <= f;
        @(posedge i_core_clk);
        cs_n <= 1'b1;
        @(posedge i_core_clk);
        #1;
        chk("valid", exp != CMD_NOP, valid);
        if (exp != CMD_NOP) begin
            chk("cmd", exp, cmd.cmd);
        end
    endtask

    task automatic lp(input logic c, input logic [9:0] r, input bus_state_e st,
                      input bus_state_e ex);
        @(posedge i_core_clk);
        cs_n <= c;
        cke <= 1'b0;
        rise <= r;
        @(posedge i_core_clk);
        cs_n <= 1'b1;
        wait_st(st);
        repeat (3) @(posedge i_core_clk);
        #1;
        chk("hold", st, state);
        @(posedge i_core_clk);
        cke <= 1'b1;
        wait_st(ex);
        repeat (2) @(posedge i_core_clk);
    endtask

    // ************
    // Main sequence
    // ************
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        cke <= 1'b1;
        #1;
        chk("state", ST_POWER_ON, state);
        chk("valid", 0, valid);
        @(posedge i_core_clk);
        rst_cmd <= 1'b1;
        @(posedge i_core_clk);
        rst_cmd <= 1'b0;
        wait_st(ST_RESETTING);
        lp(1'b1, '0, ST_RESET_PD, ST_RESETTING);
        init_done <= 1'b1;
        lp(1'b1, '0, ST_RESET_PD, ST_IDLE);
        $display("reset test done");
        ma = $random(seed);
        op = $random(seed);
        issue({ma[5:0], 4'h0}, {op, ma[7:6]}, CMD_MRW);
        chk("mr_addr", ma, cmd.mr_addr);
        chk("mr_op", op, cmd.mr_operand);
        issue({ma[5:0], 4'h8}, {op, ma[7:6]}, CMD_MRR);
        issue(10'h00c, '0, CMD_REF_ALL);
        issue(10'h004, '0, CMD_REF_BANK);
        issue(10'h007, '0, CMD_NOP);
        lp(1'b1, '0, ST_IDLE_PD, ST_IDLE);
        lp(1'b0, 10'h004, ST_SELF_REFRESH, ST_IDLE);
        $display("idle test done");
        for (int i = 0; i < 4; i++) begin
            b = $random(seed);
            row = $random(seed);
            col = $random(seed);
            issue({b, row[12:8], 2'b10}, {row[14:13], row[7:0]}, CMD_ACT);
            chk("bank", b, cmd.bank);
            chk("row", row, cmd.row);
            if (i == 0) begin
                lp(1'b1, '0, ST_ACTIVE_PD, ST_ACTIVE);
            end
            issue({b, col[2:1], 5'h01}, {col[11:3], 1'b0}, CMD_WRITE);
            chk("col", {col[11:1], 1'b0}, cmd.col);
            issue({b, col[2:1], 5'h05}, {col[11:3], i[0]}, CMD_READ);
            if (i[0]) begin
                @(posedge i_core_clk);
                #1;
                chk("ap", 1, ap_m[b]);
            end else begin
                issue(10'h003, '0, CMD_BST);
                issue({b, 7'h0b}, '0, CMD_PRE);
            end
            wait_st(ST_IDLE);
            chk("open", 0, open_m);
        end
        $display("bank test done");
        issue(10'h002, '0, CMD_ACT);
        lp(1'b0, 10'h004, ST_ERROR, ST_ERROR);
        chk("illegal", 1, illegal);
        @(posedge i_core_clk);
        i_resetn <= 1'b0;
        cke <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("illegal", 0, illegal);
        @(posedge i_core_clk);
        i_resetn <= 1'b1;
        cke <= 1'b1;
        rst_cmd <= 1'b1;
        @(posedge i_core_clk);
        rst_cmd <= 1'b0;
        wait_st(ST_RESETTING);
        @(posedge i_core_clk);
        rst_done <= 1'b1;
        @(posedge i_core_clk);
        rst_done <= 1'b0;
        wait_st(ST_IDLE);
        lp(1'b0, 10'h003, ST_DEEP_PD, ST_POWER_ON);
        $display("error test done");
        test_done();
    end

    initial begin
        #50us;
        errors++;
        $display("watchdog expired");
        test_done();
    end
endmodule
